// ---- rtl/alert_triggered_output_update.sv ----
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module alert_triggered_output_update
    import alert_gpio_pkg::*;
#(
    parameter int CHANNELS = CH_COUNT,
    parameter int ADDR_W   = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        alert_flags,
    input  wire logic [7:0]        pin_in,
    output logic [7:0]             pin_out,
    output logic [7:0]             pin_oe
);

    initial begin
        if (CHANNELS != CH_COUNT) begin
            $error("alert_triggered_output_update: register fields hold exactly eight channels");
        end
        if (ADDR_W < IDX_W + IDX_LSB) begin
            $error("alert_triggered_output_update: address too narrow for the register map");
        end
    end

    logic [7:0]        src_mask [CH_COUNT];
    logic [7:0]        trig_enable;
    logic [7:0]        trig_value;
    logic [7:0]        pin_output;
    logic [7:0]        pin_digital;
    logic [7:0]        push_pull;
    logic [7:0]        out_level;
    logic [7:0]        pin_sync;
    logic [7:0]        digital_input_state;
    logic [7:0]        trig_now;
    logic [7:0]        trig_prev;
    logic [7:0]        trig_fire;

    logic              aw_held;
    logic              w_held;
    logic [IDX_W-1:0]  wr_idx;
    logic              wr_upper_ok;
    logic [7:0]        wr_byte;
    logic              wr_lane0;
    logic              do_write;
    logic              wr_lane_hit;
    logic [7:0]        next_rd_byte;
    logic              next_rd_ok;
    logic              next_wr_ok;
    logic [IDX_W-1:0]  rd_idx;

    // Register bus: write address and data are taken independently
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane_hit   = do_write && wr_lane0 && wr_upper_ok;
    assign rd_idx        = s_axi_araddr[IDX_LSB +: IDX_W];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held     <= 1'b0;
            wr_idx      <= '0;
            wr_upper_ok <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held     <= 1'b1;
            wr_idx      <= s_axi_awaddr[IDX_LSB +: IDX_W];
            wr_upper_ok <= (s_axi_awaddr >> (IDX_LSB + IDX_W)) == '0;
        end else if (do_write) begin
            aw_held     <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            wr_byte  <= '0;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            wr_byte  <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held   <= 1'b0;
        end
    end

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < CH_COUNT; i++) begin
            if (idx == IDX_SRC_MASK[i]) begin
                hit = 1'b1;
            end
        end
        case (idx)
            IDX_TRIG_ENABLE, IDX_TRIG_VALUE, IDX_PIN_OUTPUT, IDX_PIN_DIGITAL,
            IDX_PUSH_PULL, IDX_OUT_LEVEL, IDX_IN_STATE: begin
                hit = 1'b1;
            end
            default: begin
            end
        endcase
        return hit;
    endfunction

    always_comb begin
        next_wr_ok = wr_upper_ok && idx_mapped(wr_idx);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Per-output source masks, zero to seven included, each its own register
    generate
        for (genvar o = 0; o < CH_COUNT; o++) begin : g_mask
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    src_mask[o] <= RST_SRC_MASK;
                end else if (wr_lane_hit && wr_idx == IDX_SRC_MASK[o]) begin
                    src_mask[o] <= wr_byte;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_enable <= RST_TRIG_ENABLE;
        end else if (wr_lane_hit && wr_idx == IDX_TRIG_ENABLE) begin
            trig_enable <= wr_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_value <= RST_TRIG_VALUE;
        end else if (wr_lane_hit && wr_idx == IDX_TRIG_VALUE) begin
            trig_value <= wr_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_output  <= RST_PIN_OUTPUT;
            pin_digital <= RST_PIN_DIGITAL;
            push_pull   <= RST_PUSH_PULL;
        end else if (wr_lane_hit) begin
            if (wr_idx == IDX_PIN_OUTPUT) begin
                pin_output <= wr_byte;
            end
            if (wr_idx == IDX_PIN_DIGITAL) begin
                pin_digital <= wr_byte;
            end
            if (wr_idx == IDX_PUSH_PULL) begin
                push_pull <= wr_byte;
            end
        end
    end

    // Combined trigger per output and its rising edge
    generate
        for (genvar o = 0; o < CH_COUNT; o++) begin : g_trig
            // Masked-off channels drop out of the OR entirely
            assign trig_now[o]  = |(alert_flags & src_mask[o]);
            assign trig_fire[o] = trig_now[o] && !trig_prev[o] && trig_enable[o];
        end
    endgenerate

    // Edge memory runs even while disabled, so enabling never fires on a stale level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev <= '0;
        end else begin
            trig_prev <= trig_now;
        end
    end

    // Output level: trigger wins over a software write in the same cycle
    generate
        for (genvar o = 0; o < CH_COUNT; o++) begin : g_level
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    out_level[o] <= RST_OUT_LEVEL[o];
                end else if (trig_fire[o]) begin
                    out_level[o] <= trig_value[o];
                end else if (wr_lane_hit && wr_idx == IDX_OUT_LEVEL) begin
                    out_level[o] <= wr_byte[o];
                end
            end
        end
    endgenerate

    pin_input_sync #(
        .WIDTH  (CH_COUNT),
        .STAGES (SYNC_STAGES)
    ) u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Pin modes and drivers
    generate
        for (genvar p = 0; p < CH_COUNT; p++) begin : g_pin
            pin_mode_t mode;
            logic      next_out;
            logic      next_oe;

            always_comb begin
                if (!pin_digital[p]) begin
                    mode = MODE_ANALOG;
                end else if (!pin_output[p]) begin
                    mode = MODE_DIG_IN;
                end else if (push_pull[p]) begin
                    mode = MODE_PUSH_PULL;
                end else begin
                    mode = MODE_OPEN_DRAIN;
                end
            end

            always_comb begin
                case (mode)
                    MODE_PUSH_PULL: begin
                        next_out = out_level[p];
                        next_oe  = 1'b1;
                    end
                    MODE_OPEN_DRAIN: begin
                        next_out = 1'b0;
                        next_oe  = !out_level[p];
                    end
                    default: begin
                        next_out = 1'b0;
                        next_oe  = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_out[p] <= 1'b0;
                    pin_oe[p]  <= 1'b0;
                end else begin
                    pin_out[p] <= next_out;
                    pin_oe[p]  <= next_oe;
                end
            end

            // Pins not configured as digital inputs read zero
            assign digital_input_state[p] = (mode == MODE_DIG_IN) && pin_sync[p];
        end
    endgenerate

    // Read decode
    always_comb begin
        next_rd_byte = 8'h00;
        next_rd_ok   = (s_axi_araddr >> (IDX_LSB + IDX_W)) == '0;
        case (rd_idx)
            IDX_TRIG_ENABLE: next_rd_byte = trig_enable;
            IDX_TRIG_VALUE:  next_rd_byte = trig_value;
            IDX_PIN_OUTPUT:  next_rd_byte = pin_output;
            IDX_PIN_DIGITAL: next_rd_byte = pin_digital;
            IDX_PUSH_PULL:   next_rd_byte = push_pull;
            IDX_OUT_LEVEL:   next_rd_byte = out_level;
            IDX_IN_STATE:    next_rd_byte = digital_input_state;
            default: begin
                next_rd_ok = 1'b0;
                for (int i = 0; i < CH_COUNT; i++) begin
                    if (rd_idx == IDX_SRC_MASK[i]) begin
                        next_rd_byte = src_mask[i];
                        next_rd_ok   = (s_axi_araddr >> (IDX_LSB + IDX_W)) == '0;
                    end
                end
            end
        endcase
        if (!next_rd_ok) begin
            next_rd_byte = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, next_rd_byte};
            s_axi_rresp  <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ---- rtl/alert_gpio_pkg.sv ----
package alert_gpio_pkg;

    localparam int CH_COUNT    = 8;
    localparam int DATA_W      = 32;
    localparam int IDX_W       = 8;
    localparam int IDX_LSB     = 2;
    localparam int SYNC_STAGES = 2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SRC_MASK [CH_COUNT] = '{
        8'hc3, 8'hc5, 8'hc7, 8'hc9, 8'hcb, 8'hcd, 8'hcf, 8'hd1
    };
    localparam logic [7:0] IDX_TRIG_ENABLE = 8'he9;
    localparam logic [7:0] IDX_TRIG_VALUE  = 8'heb;
    localparam logic [7:0] IDX_PIN_OUTPUT  = 8'h03;
    localparam logic [7:0] IDX_PIN_DIGITAL = 8'h05;
    localparam logic [7:0] IDX_PUSH_PULL   = 8'h07;
    localparam logic [7:0] IDX_OUT_LEVEL   = 8'h0b;
    localparam logic [7:0] IDX_IN_STATE    = 8'h0d;

    // Values after reset
    localparam logic [7:0] RST_SRC_MASK    = 8'h00;
    localparam logic [7:0] RST_TRIG_ENABLE = 8'h00;
    localparam logic [7:0] RST_TRIG_VALUE  = 8'h00;
    localparam logic [7:0] RST_PIN_OUTPUT  = 8'h00;
    localparam logic [7:0] RST_PIN_DIGITAL = 8'h00;
    localparam logic [7:0] RST_PUSH_PULL   = 8'h00;
    localparam logic [7:0] RST_OUT_LEVEL   = 8'h00;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MODE_ANALOG,
        MODE_DIG_IN,
        MODE_OPEN_DRAIN,
        MODE_PUSH_PULL
    } pin_mode_t;

endpackage

// ---- rtl/pin_input_sync.sv ----
`timescale 1ns/1ps
module pin_input_sync
    import alert_gpio_pkg::*;
#(
    parameter int WIDTH  = CH_COUNT,
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("pin_input_sync: needs at least two stages");
        end
    end

    // Only the last stage is visible outside
    logic [WIDTH-1:0] stage [STAGES];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int s = 0; s < STAGES; s++) begin
                stage[s] <= '0;
            end
        end else begin
            stage[0] <= async_in;
            for (int s = 1; s < STAGES; s++) begin
                stage[s] <= stage[s-1];
            end
        end
    end

    assign sync_out = stage[STAGES-1];

endmodule

// ---- verification/alert_gpio_checker.sv ----
`timescale 1ns/1ps
module alert_gpio_checker
    import alert_gpio_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [7:0]  alert_flags,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe
);
    logic [2:0] quiet;
    logic [7:0] prev_alert;

    // Cycles since the last bus write or alert edge; pins may only move shortly after one
    always_ff @(posedge aclk) begin
        prev_alert <= alert_flags;
        if (!aresetn || (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)
            || alert_flags != prev_alert) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    // A read answer only ever follows a taken read request
    a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("read answered without request");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_pins_quiet: assert property (quiet >= 3'h4 |-> $stable(pin_out) && $stable(pin_oe))
        else $error("pin moved with no cause");
    a_drive_needs_oe: assert property ((pin_out & ~pin_oe) == 8'h00)
        else $error("pin high without drive");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin_move: cover property (!$stable(pin_out));
endmodule

bind alert_triggered_output_update alert_gpio_checker alert_gpio_checker_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .alert_flags(alert_flags), .pin_out(pin_out), .pin_oe(pin_oe));

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import alert_gpio_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rsp;
    logic [7:0]  alert_flags, pin_in, pin_out, pin_oe, en, val, lvl, ex, pp, av;
    logic [7:0]  mask [8];
    int          mismatches, compares, cycles;

    alert_triggered_output_update alert_triggered_output_update_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .alert_flags(alert_flags), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));

    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic final_report();
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    // Handshake flags are looked at on the falling edge, when they are settled for the next rise
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'($urandom()), d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        tb = 1'h0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
    endtask

    task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        tr = 1'h0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
        end
        rready <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] i, input logic [31:0] exp);
        rdr(ad(i), rd, rsp);
        chk("register", exp, rd);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    function automatic logic [7:0] next_lvl(input logic [7:0] old, input logic [7:0] a);
        logic [7:0] r;
        r = old;
        for (int o = 0; o < 8; o++) begin
            if (en[o] && (a & mask[o]) != 8'h0) r[o] = val[o];
        end
        return r;
    endfunction

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
        {awaddr, araddr, wdata, alert_flags, pin_in} = 72'h0;
        {mismatches, compares, cycles} = {32'h0, 32'h0, 32'h0};
        void'($urandom(32'h8068));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        for (int o = 0; o < 8; o++) rchk(IDX_SRC_MASK[o], 32'h0);
        rchk(IDX_TRIG_ENABLE, 32'h0);
        rchk(IDX_TRIG_VALUE, 32'h0);
        wr(ad(IDX_PIN_OUTPUT), 8'hff, rsp);
        wr(ad(IDX_PIN_DIGITAL), 8'hff, rsp);
        wr(ad(IDX_PUSH_PULL), 8'hff, rsp);
        @(posedge aclk);
        alert_flags <= 8'hff;
        settle(4);
        chk("pin_out", 32'h0, {24'h0, pin_out});
        @(posedge aclk);
        alert_flags <= 8'h00;
        wr(12'hc00 | ad(IDX_TRIG_VALUE), 8'h5a, rsp);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        rdr(12'hc00 | ad(IDX_TRIG_VALUE), rd, rsp);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        chk("rdata", 32'h0, rd);
        // Refused write must not have landed
        rchk(IDX_TRIG_VALUE, 32'h0);
        for (int n = 0; n < 40; n++) begin
            for (int o = 0; o < 8; o++) begin
                mask[o] = 8'($urandom());
                wr(ad(IDX_SRC_MASK[o]), mask[o], rsp);
                chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
            end
            for (int o = 5; o < 8; o++) rchk(IDX_SRC_MASK[o], {24'h0, mask[o]});
            en = (n == 0) ? 8'h00 : (n == 1) ? 8'hff : 8'($urandom());
            val = 8'($urandom());
            lvl = 8'($urandom());
            pp = 8'($urandom());
            av = (n == 2) ? 8'h01 : 8'($urandom());
            wr(ad(IDX_TRIG_ENABLE), en, rsp);
            wr(ad(IDX_TRIG_VALUE), val, rsp);
            wr(ad(IDX_PUSH_PULL), pp, rsp);
            wr(ad(IDX_OUT_LEVEL), lvl, rsp);
            @(posedge aclk);
            alert_flags <= av;
            ex = next_lvl(lvl, av);
            settle(3);
            chk("pin_out", {24'h0, ex & pp}, {24'h0, pin_out});
            chk("pin_oe", {24'h0, pp | ~ex}, {24'h0, pin_oe});
            // Alert still held: a manual write must stick, no second trigger
            wr(ad(IDX_OUT_LEVEL), ~ex, rsp);
            settle(3);
            chk("pin_out", {24'h0, ~ex & pp}, {24'h0, pin_out});
            chk("pin_oe", {24'h0, pp | ex}, {24'h0, pin_oe});
            @(posedge aclk);
            alert_flags <= 8'h00;
        end
        wr(ad(IDX_PIN_OUTPUT), 8'h00, rsp);
        for (int n = 0; n < 4; n++) begin
            pp = (n == 0) ? 8'hff : 8'($urandom());
            av = 8'($urandom());
            wr(ad(IDX_PIN_DIGITAL), pp, rsp);
            @(posedge aclk);
            pin_in <= av;
            settle(4);
            rchk(IDX_IN_STATE, {24'h0, av & pp});
            chk("pin_oe", 32'h0, {24'h0, pin_oe});
        end
        final_report();
    end
endmodule
